// ### logic/sbs_defines.svh
// Constants for the flow-through burst SRAM model.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// ----------------------------------------------------------------
// Array organisation
// ----------------------------------------------------------------
`define SBS_ADDR_W     18
`define SBS_DATA_W     18
`define SBS_DEPTH      262144
`define SBS_LANES      2

// ----------------------------------------------------------------
// Field positions inside one word
// ----------------------------------------------------------------
`define SBS_LANE_BITS  8
`define SBS_PAR_LSB    16
`define SBS_BURST_W    2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBS_RST_CNT    2'h0
`define SBS_RST_DOUT   18'h00000

`endif

// ### logic/sbs_pkg.sv
// Types shared by the burst SRAM model and its bench.
// Assumes sbs_defines.svh is on the include path.
`include "sbs_defines.svh"

package sbs_pkg;

  // ----------------------------------------------------------------
  // Burst state, Gray along deselect -> active
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SBS_DESEL  = 1'b0,
    SBS_ACTIVE = 1'b1
  } sbs_mode_t;

  // Synchronous control pins, all sampled on the rising clock edge
  typedef struct packed {
    logic chip_en_n;
    logic chip_sel1;
    logic chip_sel2_n;
    logic addr_strobe_proc_n;
    logic addr_strobe_ctrl_n;
    logic burst_advance_n;
    logic all_bytes_wr_n;
    logic byte_wr_master_n;
    logic byte_lane1_wr_n;
    logic byte_lane0_wr_n;
  } sbs_ctrl_t;

  // Whole state of the controller
  typedef struct packed {
    sbs_mode_t                          mode;
    logic [`SBS_ADDR_W-1:`SBS_BURST_W]  hi;
    logic [`SBS_BURST_W-1:0]            base;
    logic [`SBS_BURST_W-1:0]            cnt;
    logic                               rd;
    logic [`SBS_DATA_W-1:0]             dout;
  } sbs_state_t;

endpackage : sbs_pkg

// ### logic/sbs_flow_sram.sv
// Synchronous flow-through burst SRAM: burst counter, byte writes, sleep.
// Assumes one clock, synchronous inputs, and a bench that resolves the data
// bus from dq_out and dq_oe_n_out.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.svh"

// Function
// RQ1: All synchronous inputs are captured only on the rising clock edge.
// RQ2: Read data appears right after the sampling edge, no extra stage.
// RQ3: Sleep high puts the memory into power-down and stops operation.
// RQ4: In power-down, array contents and internal state stay unchanged.
// RQ5: Sleep low again resumes operation from the held state.
// RQ6: An open sleep input behaves as low, meaning normal operation.
// RQ7: Sleep acts without waiting for a clock edge.
// RQ8: A 2-bit burst counter supplies the low address bits.
// RQ9: Burst order input selects interleaved or linear order.
// RQ10: Controller holds the burst order input steady in operation.
// RQ11: Writes are timed internally once registered.
// RQ12: Output enable gates the data drivers without a clock edge.
// RQ13: Per-lane byte write enables, qualified by the byte master enable.
// RQ14: Global write enable writes every lane regardless of byte enables.
// RQ15: Three chip enables, two low-active one high-active, select the part.
// RQ16: One shared data bus; drivers released unless driving read data.
// RQ17: Array holds 262,144 words of 18 bits, 18-bit address.
// RQ18: Burst advance, sampled on the edge, steps the burst counter.
// RQ19: Processor or controller address strobe loads address and starts access.
// RQ20: Interleaved order XORs start low bits with 01, 10, 11.
// RQ21: Linear order increments low bits modulo four.
// RQ22: Deselected state holds, ignoring advance, until a new begin burst.
// RQ23: Write when global enable low, or master plus any lane enable low.
// RQ24: Controller begins with a strobe then advances up to three beats; the bench advances four times so the counter wraps.
module sbs_flow_sram #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int DATA_W = `SBS_DATA_W,
  parameter int DEPTH  = `SBS_DEPTH
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire sbs_pkg::sbs_ctrl_t ctrl_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              out_en_n_in,
  input  wire logic              burst_interleave_in,
  input  wire logic              sleep_request_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n_out
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Low address bits of a beat for either burst order
  function automatic logic [1:0] burst_lo(input logic [1:0] base,
                                          input logic [1:0] cnt,
                                          input logic       ilv);
    burst_lo = ilv ? (base ^ cnt) : 2'(base + cnt); // RQ20 RQ21
  endfunction : burst_lo

  // Bit mask of lanes written; all zero means a read
  function automatic logic [DATA_W-1:0] wr_mask(input sbs_pkg::sbs_ctrl_t c);
    logic [`SBS_LANES-1:0] lanes;
    logic [DATA_W-1:0]     m;
    lanes = '0;
    m     = '0;
    if (!c.all_bytes_wr_n) begin
      lanes = '1; // RQ14
    end else if (!c.byte_wr_master_n) begin
      lanes = ~{c.byte_lane1_wr_n, c.byte_lane0_wr_n}; // RQ13
    end
    for (int i = 0; i < `SBS_LANES; i++) begin
      m[i*`SBS_LANE_BITS +: `SBS_LANE_BITS] = {`SBS_LANE_BITS{lanes[i]}};
      m[`SBS_PAR_LSB + i] = lanes[i];
    end
    wr_mask = m;
  endfunction : wr_mask

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  sbs_pkg::sbs_state_t s_q;
  sbs_pkg::sbs_state_t s_d;
  logic [DATA_W-1:0]   mem_r [DEPTH]; // RQ17
  // Upper address field is kept at full width; shrunk builds pad it
  localparam int HI_W = `SBS_ADDR_W - `SBS_BURST_W;

  logic                ce_ok;
  logic                start;
  logic                desel;
  logic                act;
  logic                adv;
  logic                wr;
  logic [DATA_W-1:0]   mask;
  logic [1:0]          cnt_nx;
  logic [ADDR_W-1:0]   eff_addr;

  // ----------------------------------------------------------------
  // Cycle decode and next state
  // ----------------------------------------------------------------

  // Strobe priority: processor strobe first, then controller, then burst
  always_comb begin
    s_d   = s_q;
    start = 1'b0;
    desel = 1'b0;
    act   = 1'b0;
    adv   = 1'b0;
    wr    = 1'b0;
    mask  = wr_mask(ctrl_in);
    ce_ok = !ctrl_in.chip_en_n && ctrl_in.chip_sel1 && !ctrl_in.chip_sel2_n; // RQ15
    if (!ctrl_in.addr_strobe_proc_n && !ctrl_in.chip_en_n) begin
      start = ce_ok; // RQ19
      desel = !ce_ok;
      mask  = '0; // Processor strobe never writes; when selected it begins a read
    end else if (!ctrl_in.addr_strobe_ctrl_n) begin
      start = ce_ok; // RQ19
      desel = !ce_ok;
    end else if (s_q.mode == sbs_pkg::SBS_ACTIVE) begin
      act = 1'b1;
      adv = !ctrl_in.burst_advance_n; // RQ18
    end
    // Advance is ignored while deselected
    act    = act || start; // RQ22
    wr     = act && (mask != '0); // RQ23
    cnt_nx = 2'(s_q.cnt + {1'b0, adv}); // RQ8
    eff_addr = start ? addr_in
                     : ADDR_W'({s_q.hi, burst_lo(s_q.base, cnt_nx, burst_interleave_in)}); // RQ9
    // Sleep freezes everything; writes are also suppressed below
    if (!sleep_request_in) begin // RQ4 RQ5 RQ6
      if (start) begin
        s_d.mode = sbs_pkg::SBS_ACTIVE;
        s_d.hi   = HI_W'(addr_in[ADDR_W-1:`SBS_BURST_W]);
        s_d.base = addr_in[`SBS_BURST_W-1:0];
        s_d.cnt  = `SBS_RST_CNT;
      end else if (desel) begin
        s_d.mode = sbs_pkg::SBS_DESEL; // RQ22
      end else begin
        s_d.cnt = cnt_nx; // RQ18
      end
      s_d.rd = act && !wr;
      // Array read lands at the same edge that takes the address
      if (act && !wr) begin
        s_d.dout = mem_r[eff_addr]; // RQ2
      end
    end
  end

  // Control register, the only reset state
  always_ff @(posedge clk_in or negedge nrst_in) begin // RQ1
    if (!nrst_in) begin
      s_q <= '{mode: sbs_pkg::SBS_DESEL, hi: '0, base: `SBS_RST_CNT,
               cnt: `SBS_RST_CNT, rd: 1'b0, dout: `SBS_RST_DOUT};
    end else begin
      s_q <= s_d;
    end
  end

  // Self-timed write: the registered edge commits the masked lanes
  always_ff @(posedge clk_in) begin // RQ11
    if (wr && !sleep_request_in && nrst_in) begin
      mem_r[eff_addr] <= (mem_r[eff_addr] & ~mask) | (dq_in & mask); // RQ13
    end
  end

  // ----------------------------------------------------------------
  // Data bus drivers
  // ----------------------------------------------------------------

  // Enable stays combinational on purpose: output enable and sleep are
  // asynchronous, so a register here would add a clock of latency.
  // Limitation: dq_out keeps the last read word while the bus is released.
  assign dq_out      = s_q.dout;
  assign dq_oe_n_out = !(s_q.rd && !out_en_n_in && !sleep_request_in); // RQ12 RQ16 RQ7 RQ3

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence read_taken;
    act && !wr && !sleep_request_in;
  endsequence

  sequence oe_low_next;
    !out_en_n_in && !sleep_request_in;
  endsequence

  // A begin burst that the sleep input let through
  sequence burst_begun;
    start && !sleep_request_in;
  endsequence

  // The cycle after it, stepping to the first beat
  sequence first_step;
    act && !start && adv && !sleep_request_in;
  endsequence

  AST_DESEL_HOLDS: assert property ( // RQ22
    s_q.mode == sbs_pkg::SBS_DESEL && !start && !sleep_request_in
      |=> s_q.mode == sbs_pkg::SBS_DESEL && s_q.cnt == $past(s_q.cnt))
    else $error("deselected state left without begin burst");

  AST_SLEEP_FREEZE: assert property ( // RQ4
    sleep_request_in |=> s_q == $past(s_q))
    else $error("state changed during sleep");

  AST_SLEEP_HIZ: assert property ( // RQ3
    sleep_request_in |-> dq_oe_n_out)
    else $error("bus driven during sleep");

  AST_OE_GATES: assert property ( // RQ12
    out_en_n_in |-> dq_oe_n_out)
    else $error("bus driven with output enable high");

  AST_ADV_STEP: assert property ( // RQ18
    act && !start && adv && !sleep_request_in
      |=> s_q.cnt == 2'($past(s_q.cnt) + 2'h1))
    else $error("advance did not step the counter");

  AST_START_LOAD: assert property ( // RQ19
    start && !sleep_request_in
      |=> s_q.cnt == 2'h0 && s_q.base == $past(addr_in[1:0])
          && s_q.mode == sbs_pkg::SBS_ACTIVE)
    else $error("begin burst did not load address");

  AST_ILV_ORDER: assert property ( // RQ20
    act && !start && burst_interleave_in
      |-> eff_addr[1:0] == (s_q.base ^ cnt_nx))
    else $error("interleaved order wrong");

  AST_LIN_ORDER: assert property ( // RQ21
    act && !start && !burst_interleave_in
      |-> eff_addr[1:0] == 2'(s_q.base + cnt_nx))
    else $error("linear order wrong");

  AST_READ_DRIVES: assert property ( // RQ2
    read_taken ##1 oe_low_next |-> !dq_oe_n_out)
    else $error("read data not driven after sampling edge");

  AST_WRITE_HIZ: assert property ( // RQ16
    wr && !sleep_request_in |=> dq_oe_n_out)
    else $error("bus driven after write cycle");

  AST_DESEL_CE: assert property ( // RQ15
    desel && !sleep_request_in |=> s_q.mode == sbs_pkg::SBS_DESEL && dq_oe_n_out)
    else $error("chip enables failed to deselect");

  AST_GW_ALL: assert property ( // RQ14
    !ctrl_in.all_bytes_wr_n && ctrl_in.addr_strobe_proc_n && act |-> wr && mask == '1)
    else $error("global write did not cover all lanes");

  // ----------------------------------------------------------------
  // Further checks, tying the decode terms to pin values
  // ----------------------------------------------------------------
  AST_ILV_FIRST: assert property ( // RQ20
    burst_begun ##1 first_step
      |-> !burst_interleave_in || eff_addr[1:0] == ($past(addr_in[1:0]) ^ 2'h1))
    else $error("first interleaved beat address wrong");

  AST_LIN_FIRST: assert property ( // RQ21
    burst_begun ##1 first_step
      |-> burst_interleave_in || eff_addr[1:0] == 2'($past(addr_in[1:0]) + 2'h1))
    else $error("first linear beat address wrong");

  AST_SUSPEND_HOLD: assert property ( // RQ18
    act && !start && !adv && !sleep_request_in |=> s_q.cnt == $past(s_q.cnt))
    else $error("suspend moved the burst counter");

  AST_DOUT_HOLD: assert property ( // RQ2
    !(act && !wr) |=> dq_out == $past(dq_out))
    else $error("read data changed without a read");

  AST_LANE_MASK: assert property ( // RQ13
    act && ctrl_in.addr_strobe_proc_n && ctrl_in.all_bytes_wr_n && !ctrl_in.byte_wr_master_n
      |-> mask == {!ctrl_in.byte_lane1_wr_n, !ctrl_in.byte_lane0_wr_n,
                   {`SBS_LANE_BITS{!ctrl_in.byte_lane1_wr_n}},
                   {`SBS_LANE_BITS{!ctrl_in.byte_lane0_wr_n}}})
    else $error("byte lane mask wrong");

  AST_NO_WRITE_READ: assert property ( // RQ23
    act && ctrl_in.all_bytes_wr_n
      && (ctrl_in.byte_wr_master_n || (ctrl_in.byte_lane1_wr_n && ctrl_in.byte_lane0_wr_n))
      |-> !wr)
    else $error("cycle without write enables wrote");

  AST_PROC_READ: assert property ( // RQ19
    start && !ctrl_in.addr_strobe_proc_n && !sleep_request_in |=> s_q.rd)
    else $error("processor strobe begin did not read");

  AST_DESEL_IDLE: assert property ( // RQ22
    s_q.mode == sbs_pkg::SBS_DESEL |-> !s_q.rd && dq_oe_n_out)
    else $error("deselected part still reading");

  AST_LOAD_HI: assert property ( // RQ19
    burst_begun
      |=> s_q.hi == HI_W'($past(addr_in[ADDR_W-1:`SBS_BURST_W])))
    else $error("begin burst did not load upper address");

endmodule : sbs_flow_sram

`default_nettype wire

// ### verification/sbs_bus_model.sv
// Far-side bus model: resolves the shared data bus of the burst SRAM.
// Assumes the device drives while its enable is low, the host while drive is set.
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_model (
  input  wire logic        clk_in,
  input  wire logic [17:0] dev_dq_in,
  input  wire logic        dev_oe_n_in,
  input  wire logic [17:0] host_dq_in,
  input  wire logic        host_drive_in,
  output logic      [17:0] bus_out
);
  logic [17:0] last_q;

  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // No pull on the bus, so a released bus shows a changing pattern, not old data
  always_comb begin
    if (!dev_oe_n_in && host_drive_in) bus_out = 'x;
    else if (!dev_oe_n_in) bus_out = dev_dq_in;
    else if (host_drive_in) bus_out = host_dq_in;
    else bus_out = ~last_q;
  end

  // Last level seen, inverted while floating
  always_ff @(posedge clk_in) last_q <= bus_out;
endmodule : sbs_bus_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the flow-through burst SRAM, shrunk to 64 words.
// Assumes sbs_bus_model resolves the data bus and drives the device's dq_in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t ns: got %h exp %h", $time, got, exp); end end
module tb_top;
  logic               clk_in = 1'b0;
  logic               nrst_in = 1'b0;
  logic               out_en_n_in = 1'b1;
  logic               ilv = 1'b1;
  logic               sleep_q = 1'b0;
  logic               drv = 1'b0;
  sbs_pkg::sbs_ctrl_t ctrl = 10'h17f;
  logic [5:0]         addr = 6'h00;
  logic [17:0]        hdq = 18'h00000;
  logic [17:0]        bus;
  logic [17:0]        dq_o;
  logic               oe_n;
  logic [17:0]        mem [64];
  logic [31:0]        seed = 32'h00000019;
  logic [31:0]        r;
  logic [5:0]         a;
  logic [9:0]         lane_c [3] = '{10'h15a, 10'h159, 10'h15b};
  logic [9:0]         dsel_c [3] = '{10'h05f, 10'h1bf, 10'h35f};
  int                 errors = 0;
  int                 tests_run = 0;

  // ----------------------------------------
  // Clock, device and bus
  // ----------------------------------------
  always #2.5 clk_in = ~clk_in;

  sbs_flow_sram #(.ADDR_W(6), .DATA_W(18), .DEPTH(64)) i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .ctrl_in(ctrl), .addr_in(addr),
    .dq_in(bus), .out_en_n_in(out_en_n_in), .burst_interleave_in(ilv),
    .sleep_request_in(sleep_q), .dq_out(dq_o), .dq_oe_n_out(oe_n));

  sbs_bus_model i_bus (.clk_in(clk_in), .dev_dq_in(dq_o), .dev_oe_n_in(oe_n),
    .host_dq_in(hdq), .host_drive_in(drv), .bus_out(bus));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Low address bits of burst beat k
  function automatic logic [1:0] nxt(input logic [1:0] b, input logic [1:0] k);
    return ilv ? (b ^ k) : (b + k);
  endfunction : nxt

  // Mode only moves under reset, never mid-operation
  task automatic do_rst(input logic m);
    nrst_in = 1'b0;
    ilv = m;
    repeat (5) @(posedge clk_in);
    `CHK(oe_n, 1'b1)
    #1 nrst_in = 1'b1;
  endtask : do_rst

  // One bus cycle; host drives data and blocks the device whenever global or byte master write enable is low
  task automatic cyc(input logic [9:0] c, input logic [5:0] ad, input logic [17:0] d);
    ctrl = c;
    addr = ad;
    hdq = d;
    drv = !c[3] || !c[2];
    out_en_n_in = drv;
    @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic rd_chk(input logic [17:0] e);
    `CHK(oe_n, 1'b0)
    `CHK(bus, e)
  endtask : rd_chk

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    do_rst(1'b1);
    for (int i = 0; i < 64; i++) begin
      r = xs();
      mem[i] = r[17:0];
      cyc(10'h157, 6'(i), mem[i]);
      `CHK(oe_n, 1'b1)
    end
    // Lane 0, lane 1, then master without lanes, which is a read
    a = r[23:18];
    for (int k = 0; k < 3; k++) begin
      r = xs();
      cyc(lane_c[k], a, r[17:0]);
      if (k == 0) {mem[a][16], mem[a][7:0]} = {r[16], r[7:0]};
      if (k == 1) {mem[a][17], mem[a][15:8]} = {r[17], r[15:8]};
      cyc(10'h13f, a, 18'h00000);
      rd_chk(mem[a]);
    end
    // Four advances wrap, then a suspend rereads
    for (int m = 0; m < 2; m++) begin
      do_rst(m[0]);
      r = xs();
      a = r[5:0];
      cyc(10'h15f, a, 18'h00000);
      rd_chk(mem[a]);
      for (int k = 1; k < 6; k++) begin
        cyc(k < 5 ? 10'h16f : 10'h17f, 6'h00, 18'h00000);
        rd_chk(mem[{a[5:2], nxt(a[1:0], (k == 5) ? 2'h0 : k[1:0])}]);
      end
    end
    for (int k = 0; k < 3; k++) begin
      cyc(dsel_c[k], a, 18'h00000);
      `CHK(oe_n, 1'b1)
      cyc(10'h16f, a, 18'h00000);
      `CHK(oe_n, 1'b1)
    end
    // Output enable and sleep act between clock edges
    cyc(10'h15f, a, 18'h00000);
    rd_chk(mem[a]);
    out_en_n_in = 1'b1;
    #1 `CHK(oe_n, 1'b1)
    out_en_n_in = 1'b0;
    #1 `CHK(oe_n, 1'b0)
    sleep_q = 1'b1;
    #1 `CHK(oe_n, 1'b1)
    @(posedge clk_in);
    #1;
    cyc(10'h157, a, ~mem[a]);
    sleep_q = 1'b0;
    cyc(10'h17f, a, 18'h00000);
    rd_chk(mem[a]);
    finish_test();
  end

  // Watchdog, far beyond the roughly 110 cycles the run needs
  initial begin
    #20000;
    errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
